// ==== verilog/msr_pkg.sv ====
`default_nettype none
package msr_pkg;
	// Clock and bit timing
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int BIT_NS = 833_333;
	localparam int BIT_CYC_DEF = BIT_NS / CLK_NS;
	// Async output rates in tenths of bit/s: +1 % and +2.3 % overspeed
	localparam int OVS_STD_BPSX10 = 12_120;
	localparam int OVS_EXT_BPSX10 = 12_276;
	localparam int OVS_STD_CYC_DEF = (CLK_HZ * 10 + OVS_STD_BPSX10 - 1) / OVS_STD_BPSX10;
	localparam int OVS_EXT_CYC_DEF = (CLK_HZ * 10 + OVS_EXT_BPSX10 - 1) / OVS_EXT_BPSX10;
	localparam int STOP_NUM = 7;
	localparam int STOP_DEN = 8;
	localparam logic [5:0] BRK_ADD = 6'h03;
	// Scrambler taps for 1 + x^-14 + x^-17
	localparam int SCR_LEN = 17;
	localparam int SCR_TAP_A = 13;
	localparam int SCR_TAP_B = 16;
	// Register map
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control fields
	localparam int B_SYNC = 0;
	localparam int B_XOVS = 2;
	localparam int B_SCRBYP = 3;
	localparam int B_ANS = 4;
	localparam int B_ALB = 5;
	localparam int B_BACK = 6;
	localparam int F_TSRC = 8;
	localparam int F_MODE = 10;
	localparam int F_NBITS = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_a000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_ff7d;
	localparam logic [1:0] TSRC_INT = 2'h0;
	localparam logic [1:0] TSRC_SLAVE = 2'h1;
	localparam logic [1:0] TSRC_EXT = 2'h2;
	localparam logic [1:0] MODE_PSK = 2'h0;
	localparam logic [1:0] MODE_FSK300 = 2'h1;
	localparam logic [1:0] MODE_FSK1200 = 2'h2;
	// Phase changes in quarter turns
	localparam logic [1:0] PH_0 = 2'h0;
	localparam logic [1:0] PH_90 = 2'h1;
	localparam logic [1:0] PH_180 = 2'h2;
	localparam logic [1:0] PH_270 = 2'h3;
	// Tone frequencies in Hz
	localparam logic [11:0] HZ_1200 = 12'h4b0;
	localparam logic [11:0] HZ_2400 = 12'h960;
	localparam logic [11:0] HZ_1270 = 12'h4f6;
	localparam logic [11:0] HZ_1070 = 12'h42e;
	localparam logic [11:0] HZ_2225 = 12'h8b1;
	localparam logic [11:0] HZ_2025 = 12'h7e9;
	localparam logic [11:0] HZ_2200 = 12'h898;
	localparam logic [11:0] HZ_387 = 12'h183;
	localparam logic [11:0] HZ_487 = 12'h1e7;
	localparam int FIFO_AW = 4;
	typedef enum logic {TA_IDLE, TA_BITS} msr_ta_t;
endpackage
`default_nettype wire

// ==== verilog/msr_top.sv ====
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module msr_top #(
	parameter int BIT_CYC = msr_pkg::BIT_CYC_DEF,
	parameter int OVS_STD_CYC = msr_pkg::OVS_STD_CYC_DEF,
	parameter int OVS_EXT_CYC = msr_pkg::OVS_EXT_CYC_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [msr_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [msr_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic txd_in,
	input wire logic external_timing_clock,
	input wire logic carrier_detect,
	input wire logic [1:0] dem_phase,
	input wire logic dem_phase_stb,
	input wire logic dem_fsk_bit,
	output logic rxd_out,
	output logic rx_bit_clock,
	output logic tx_bit_clock,
	output logic [1:0] mod_phase,
	output logic mod_phase_stb,
	output logic mod_fsk_bit,
	output logic [11:0] tx_mark_hz,
	output logic [11:0] tx_space_hz,
	output logic [11:0] rx_carrier_hz
);
	import msr_pkg::*;

	localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
	localparam logic [15:0] BIT_HALF = 16'(BIT_CYC / 2);
	localparam logic [15:0] STD_LAST = 16'(OVS_STD_CYC - 1);
	localparam logic [15:0] EXT_LAST = 16'(OVS_EXT_CYC - 1);
	localparam logic [15:0] STOP_LAST = 16'(OVS_EXT_CYC * STOP_NUM / STOP_DEN - 1);

	// Register decode, shared by read and write paths
	function automatic logic [1:0] reg_sel(input logic [AXI_AW-1:0] a);
		if (a == REG_CTRL) reg_sel = 2'h1;
		else if (a == REG_STAT) reg_sel = 2'h2;
		else reg_sel = 2'h0;
	endfunction

	// Gray mapping of a bit pair onto a phase change
	function automatic logic [1:0] enc_phase(input logic [1:0] p);
		case (p)
			2'h0: enc_phase = PH_90;
			2'h1: enc_phase = PH_0;
			2'h3: enc_phase = PH_270;
			default: enc_phase = PH_180;
		endcase
	endfunction

	function automatic logic [1:0] dec_phase(input logic [1:0] ph);
		case (ph)
			PH_90: dec_phase = 2'h0;
			PH_0: dec_phase = 2'h1;
			PH_270: dec_phase = 2'h3;
			default: dec_phase = 2'h2;
		endcase
	endfunction

	logic [31:0] ctrl, act;
	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic aw_hold, w_hold, wr_fire;
	logic [1:0] txd_sync, ext_sync;
	logic ext_prev, ext_rise, txd_s;
	logic [15:0] tx_cnt, ta_cnt, rx_cnt, out_cnt;
	logic int_tick, tx_tick, rx_emit, rx_clk_rise;
	logic sync_m, fsk_m;
	logic [3:0] nbits, ta_idx, fr_idx;
	logic [15:0] ta_sh, ser_sh;
	logic ta_zero, hold_full, hold_brk, ser_brk, tx_brk, rx_brk;
	logic [15:0] hold_ch;
	logic [5:0] ser_left;
	logic tx_bit, scr_bit, di_half, di_first;
	logic [SCR_LEN-1:0] scr, dsc;
	logic rx_pend, rx_second, rx_raw, rx_d, fr_one, fr_prev_zero;
	logic [1:0] fifo [0:(1<<FIFO_AW)-1];
	logic [FIFO_AW-1:0] wp, rp;
	msr_ta_t ta_st;

	assign sync_m = act[B_SYNC];
	assign fsk_m = act[F_MODE+1 -: 2] != MODE_PSK;
	assign nbits = act[F_NBITS+3 -: 4];
	assign txd_s = txd_sync[1];
	assign ext_rise = ext_sync[1] & ~ext_prev;
	assign wr_fire = aw_hold & w_hold & ~s_axi_bvalid;

	// txd_in and external_timing_clock pass two flops; only the second is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd_sync <= 2'h3;
			ext_sync <= 2'h0;
			ext_prev <= 1'b0;
		end else begin
			txd_sync <= {txd_sync[0], txd_in};
			ext_sync <= {ext_sync[0], external_timing_clock};
			ext_prev <= ext_sync[1];
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end else if (!aw_hold && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (!w_hold && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (reg_sel(wr_addr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register with byte strobes; status writes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
		end else if (wr_fire && reg_sel(wr_addr) == 2'h1) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_strb[i]) ctrl[i*8 +: 8] <= wr_data[i*8 +: 8] & CTRL_MASK[i*8 +: 8];
			end
		end
	end

	// Read channel, one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				2'h1: s_axi_rdata <= ctrl;
				2'h2: s_axi_rdata <= {24'h0, 2'h0, 1'b0, hold_full, rx_brk,
					tx_brk, sync_m, carrier_detect};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Mode changes land on an internal bit tick, or at once while in an FSK mode; an idle link clock can't stall
	always_ff @(posedge aclk) begin
		if (!aresetn) act <= CTRL_RST;
		else if (int_tick || fsk_m) act <= ctrl;
	end

	// Internal bit clock at 1200 bit/s
	always_ff @(posedge aclk) begin
		if (!aresetn) tx_cnt <= '0;
		else tx_cnt <= (tx_cnt == BIT_LAST) ? '0 : tx_cnt + 16'h1;
	end
	assign int_tick = tx_cnt == BIT_LAST;

	// Transmit bit timing source
	always_comb begin
		tx_tick = int_tick;
		if (sync_m) begin
			case (act[F_TSRC+1 -: 2])
				TSRC_SLAVE: tx_tick = rx_clk_rise;
				TSRC_EXT: tx_tick = ext_rise;
				default: tx_tick = int_tick;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) tx_bit_clock <= 1'b0;
		else if (sync_m && act[F_TSRC+1 -: 2] == TSRC_SLAVE) tx_bit_clock <= rx_bit_clock;
		else if (sync_m && act[F_TSRC+1 -: 2] == TSRC_EXT) tx_bit_clock <= ext_sync[1];
		else tx_bit_clock <= tx_cnt >= BIT_HALF;
	end

	// Character sampler on the terminal side; samples mid-bit so the
	// terminal's rate error is absorbed within a character
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ta_st <= TA_IDLE;
			ta_cnt <= '0;
			ta_idx <= 4'h0;
			ta_sh <= '0;
			ta_zero <= 1'b1;
		end else begin
			case (ta_st)
				TA_IDLE: begin
					if (!txd_s && !sync_m && !fsk_m) begin
						ta_st <= TA_BITS;
						ta_cnt <= BIT_HALF;
						ta_idx <= 4'h0;
						ta_zero <= 1'b1;
					end
				end
				TA_BITS: begin
					if (ta_cnt == 16'h0) begin
						ta_cnt <= BIT_LAST;
						ta_sh[ta_idx] <= txd_s;
						ta_zero <= ta_zero & ~txd_s;
						ta_idx <= ta_idx + 4'h1;
						if (ta_idx == nbits - 4'h1) ta_st <= TA_IDLE;
					end else begin
						ta_cnt <= ta_cnt - 16'h1;
					end
				end
				default: ta_st <= TA_IDLE;
			endcase
		end
	end

	// Sync serializer: idles on mark (added stops), drops a stop when the
	// next character is already waiting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_full <= 1'b0;
			hold_brk <= 1'b0;
			hold_ch <= '0;
			ser_sh <= '0;
			ser_left <= '0;
			ser_brk <= 1'b0;
			tx_bit <= 1'b1;
		end else begin
			if (tx_tick) begin
				if (sync_m) begin
					tx_bit <= txd_s;
				end else if (hold_full && (ser_left == 6'h0 ||
					(ser_left == 6'h1 && !ser_brk))) begin
					hold_full <= 1'b0;
					tx_bit <= hold_brk ? 1'b0 : hold_ch[0];
					ser_sh <= hold_brk ? 16'h0 : hold_ch >> 1;
					ser_brk <= hold_brk;
					ser_left <= hold_brk ? {1'b0, nbits, 1'b0} + BRK_ADD - 6'h1
						: {2'h0, nbits} - 6'h1;
				end else if (ser_left != 6'h0) begin
					tx_bit <= ser_sh[0];
					ser_sh <= ser_sh >> 1;
					ser_left <= ser_left - 6'h1;
				end else begin
					tx_bit <= 1'b1;
					ser_brk <= 1'b0;
				end
			end
			// Last, so a character ending as the hold empties is not lost;
			// its final sample lands on this same edge, so merge it here
			if (ta_st == TA_BITS && ta_cnt == 16'h0 && ta_idx == nbits - 4'h1) begin
				hold_full <= 1'b1;
				hold_ch <= ta_sh;
				hold_ch[ta_idx] <= txd_s;
				hold_brk <= ta_zero & ~txd_s;
			end
		end
	end
	assign tx_brk = ser_brk;

	// Scrambler, then bit pairs onto phase changes
	assign scr_bit = act[B_SCRBYP] ? tx_bit : tx_bit ^ scr[SCR_TAP_A] ^ scr[SCR_TAP_B];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scr <= '0;
			di_half <= 1'b0;
			di_first <= 1'b0;
			mod_phase <= PH_0;
			mod_phase_stb <= 1'b0;
			mod_fsk_bit <= 1'b1;
		end else begin
			mod_phase_stb <= 1'b0;
			mod_fsk_bit <= txd_s;
			if (int_tick && !fsk_m) begin
				scr <= {scr[SCR_LEN-2:0], scr_bit};
				di_half <= ~di_half;
				di_first <= scr_bit;
				if (di_half) begin
					mod_phase <= enc_phase({di_first, scr_bit});
					mod_phase_stb <= 1'b1;
				end
			end
		end
	end

	// Receive: one phase change yields two bits, one bit period apart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt <= '0;
			rx_pend <= 1'b0;
			rx_second <= 1'b0;
			rx_raw <= 1'b1;
			rx_emit <= 1'b0;
		end else begin
			rx_emit <= 1'b0;
			if (dem_phase_stb && !fsk_m) begin
				{rx_raw, rx_second} <= dec_phase(dem_phase);
				rx_pend <= 1'b1;
				rx_emit <= 1'b1;
				rx_cnt <= BIT_LAST;
			end else if (rx_cnt == 16'h0) begin
				rx_cnt <= BIT_LAST;
				if (rx_pend) begin
					rx_raw <= rx_second;
					rx_pend <= 1'b0;
					rx_emit <= 1'b1;
				end
			end else begin
				rx_cnt <= rx_cnt - 16'h1;
			end
		end
	end
	assign rx_clk_rise = rx_cnt == BIT_HALF;

	// Receive clock falls as each bit is presented, rises mid-bit
	always_ff @(posedge aclk) begin
		if (!aresetn) rx_bit_clock <= 1'b0;
		else if (!carrier_detect || rx_emit) rx_bit_clock <= 1'b0;
		else if (rx_clk_rise) rx_bit_clock <= 1'b1;
	end

	// Descrambler feeds back the received bit, so it resynchronises alone
	assign rx_d = act[B_SCRBYP] ? rx_raw : rx_raw ^ dsc[SCR_TAP_A] ^ dsc[SCR_TAP_B];
	always_ff @(posedge aclk) begin
		if (!aresetn) dsc <= '0;
		else if (rx_emit) dsc <= {dsc[SCR_LEN-2:0], rx_raw};
	end

	// Framer: restores deleted stop bits; all-zero characters pass as is.
	// Entries carry {is_stop, bit}; the faster output drains the extra stop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp <= '0;
			fr_idx <= 4'h0;
			fr_one <= 1'b0;
			fr_prev_zero <= 1'b0;
			rx_brk <= 1'b0;
		end else if (rx_emit && !sync_m) begin
			if (fr_idx == 4'h0) begin
				fifo[wp] <= {rx_d, rx_d};
				wp <= wp + 1'b1;
				fr_one <= 1'b0;
				if (!rx_d) fr_idx <= 4'h1;
			end else if (fr_idx == nbits - 4'h1) begin
				fr_prev_zero <= ~fr_one & ~rx_d;
				rx_brk <= fr_prev_zero & ~fr_one & ~rx_d;
				if (!rx_d && fr_one) begin
					fifo[wp] <= 2'h3;
					fifo[wp + 1'b1] <= 2'h0;
					wp <= wp + 2'h2;
					fr_idx <= 4'h1;
					fr_one <= 1'b0;
				end else begin
					fifo[wp] <= {rx_d, rx_d};
					wp <= wp + 1'b1;
					fr_idx <= 4'h0;
				end
			end else begin
				fifo[wp] <= {1'b0, rx_d};
				wp <= wp + 1'b1;
				fr_one <= fr_one | rx_d;
				fr_idx <= fr_idx + 4'h1;
			end
		end
	end

	// Data output: mark without carrier, direct in FSK and sync modes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rp <= '0;
			out_cnt <= '0;
			rxd_out <= 1'b1;
		end else if (!carrier_detect) begin
			rxd_out <= 1'b1;
			rp <= wp;
		end else if (fsk_m) begin
			rxd_out <= dem_fsk_bit;
		end else if (sync_m) begin
			if (rx_emit) rxd_out <= rx_d;
		end else if (out_cnt != 16'h0) begin
			out_cnt <= out_cnt - 16'h1;
		end else if (rp != wp) begin
			rxd_out <= fifo[rp][0];
			rp <= rp + 1'b1;
			if (!act[B_XOVS]) out_cnt <= STD_LAST;
			else if (fifo[rp][1]) out_cnt <= STOP_LAST;
			else out_cnt <= EXT_LAST;
		end
	end

	// Carrier and tone selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_mark_hz <= HZ_1200;
			tx_space_hz <= HZ_1200;
			rx_carrier_hz <= HZ_2400;
		end else begin
			case (act[F_MODE+1 -: 2])
				MODE_FSK300: begin
					tx_mark_hz <= act[B_ANS] ? HZ_2225 : HZ_1270;
					tx_space_hz <= act[B_ANS] ? HZ_2025 : HZ_1070;
					rx_carrier_hz <= act[B_ANS] ? HZ_1270 : HZ_2225;
				end
				MODE_FSK1200: begin
					tx_mark_hz <= act[B_BACK] ? HZ_387 : HZ_1200;
					tx_space_hz <= act[B_BACK] ? HZ_487 : HZ_2200;
					rx_carrier_hz <= act[B_BACK] ? HZ_387 : HZ_1200;
				end
				default: begin
					tx_mark_hz <= act[B_ANS] ? HZ_2400 : HZ_1200;
					tx_space_hz <= act[B_ANS] ? HZ_2400 : HZ_1200;
					rx_carrier_hz <= (act[B_ANS] ^ act[B_ALB]) ? HZ_1200 : HZ_2400;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== testbench/msr_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_top_asserts
	import msr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic carrier_detect,
	input wire logic rxd_out,
	input wire logic rx_bit_clock,
	input wire logic [1:0] mod_phase,
	input wire logic mod_phase_stb
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Handshake steps that open a register access (write address and data taken in one cycle), and three cycles without carrier
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_no_carrier;
		!carrier_detect [*3];
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");
	a_busy_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("new write accepted while response pending");
	a_resp_code: assert property (s_axi_bvalid |->
		s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
		else $error("bad write response code");
	a_stb_pulse: assert property (mod_phase_stb |=> !mod_phase_stb)
		else $error("phase strobe longer than one cycle");
	a_phase_steady: assert property (!mod_phase_stb |-> $stable(mod_phase))
		else $error("phase changed without strobe");
	a_mark_idle: assert property (s_no_carrier |-> rxd_out)
		else $error("receive data not mark without carrier");
	a_rx_bit_clock_idle: assert property (s_no_carrier |-> !rx_bit_clock)
		else $error("receive clock runs without carrier");
endmodule
bind msr_top msr_top_asserts u_asserts (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .carrier_detect, .rxd_out,
	.rx_bit_clock, .mod_phase, .mod_phase_stb
);
`default_nettype wire

// ==== testbench/msr_term_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Terminal serial port: async characters, levels, external clock bursts
module msr_term_model (
	input wire logic aclk,
	output logic txd,
	output logic ext_clk
);
	// Line idles at mark, external clock stands low between bursts
	initial begin
		txd = 1'b1;
		ext_clk = 1'b0;
	end
	// One character, first bit first; cyc sets how fast the terminal runs
	task automatic send_char(input int n, input logic [15:0] bits,
		input int cyc);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			txd <= bits[i];
			repeat (cyc - 1) @(posedge aclk);
		end
		@(posedge aclk);
		txd <= 1'b1;
	endtask
	task automatic set_level(input logic b);
		@(posedge aclk);
		txd <= b;
	endtask
	// Data moves on the falling edge so it is settled at each rise
	task automatic ext_burst(input int n, input logic [31:0] pat);
		#7;
		for (int i = 0; i < n; i++) begin
			ext_clk = 1'b1;
			#160;
			ext_clk = 1'b0;
			txd = pat[i % 32];
			#160;
		end
		txd = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== testbench/msr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_top_tb;
	import msr_pkg::*;
	localparam int BC = 40;
	localparam int LIM = 2000;
	logic aclk, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dem_phase_stb = 1'b0;
	logic carrier_detect = 1'b0, dem_fsk_bit = 1'b1, rb, rxc_q, txc_q;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] dem_phase = 2'h0, mod_phase, s_axi_bresp, s_axi_rresp, pb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, txd_in, external_timing_clock, rxd_out;
	logic rx_bit_clock, tx_bit_clock, mod_phase_stb, mod_fsk_bit;
	logic [11:0] tx_mark_hz, tx_space_hz, rx_carrier_hz;
	logic [1:0] last_ph, exp_b[$], exp_rr[$];
	logic [31:0] exp_rd[$];
	logic exp_bit[$];
	int fails = 0, cmp_count = 0, seed = 11, run = 0, max_zero = 0;
	int ph_seen = 0, txc_cnt = 0;
	msr_top #(.BIT_CYC(BC), .OVS_STD_CYC(38), .OVS_EXT_CYC(37)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .txd_in, .external_timing_clock,
		.carrier_detect, .dem_phase, .dem_phase_stb, .dem_fsk_bit,
		.rxd_out, .rx_bit_clock, .tx_bit_clock, .mod_phase,
		.mod_phase_stb, .mod_fsk_bit, .tx_mark_hz, .tx_space_hz,
		.rx_carrier_hz
	);
	msr_term_model term (.aclk, .txd(txd_in), .ext_clk(external_timing_clock));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic guard(input int t);
		if (t >= LIM) begin
			fails++;
			report_and_stop();
		end
	endtask
	// Pair carried by a phase change, first bit in the high place
	function automatic logic [1:0] pair_of(input logic [1:0] p);
		case (p)
			PH_90: return 2'b00;
			PH_0: return 2'b01;
			PH_270: return 2'b11;
			default: return 2'b10;
		endcase
	endfunction
	// Address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int t;
		logic aw_ok, w_ok;
		exp_b.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
			aw_ok = aw_ok | s_axi_awready;
			w_ok = w_ok | s_axi_wready;
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
			guard(t);
		end while (!(aw_ok && w_ok && s_axi_bvalid));
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int t;
		logic ar_ok;
		exp_rd.push_back(d);
		exp_rr.push_back(r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ar_ok = 1'b0;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
			ar_ok = ar_ok | s_axi_arready;
			if (ar_ok)
				s_axi_arvalid <= 1'b0;
			guard(t);
		end while (!(ar_ok && s_axi_rvalid));
		s_axi_rready <= 1'b0;
	endtask
	// Tone flags: bit 0 answer, bit 1 loopback, bit 2 back channel
	task automatic tone_case(input logic [1:0] m, input logic [2:0] f,
		input logic [11:0] mk, input logic [11:0] sp, input logic [11:0] rc);
		axi_write(REG_CTRL, CTRL_RST | 32'(m) << F_MODE | 32'(f[0]) << B_ANS
			| 32'(f[1]) << B_ALB | 32'(f[2]) << B_BACK, RESP_OKAY);
		repeat (3 * BC) @(posedge aclk);
		chk("tx_mark_hz", mk, tx_mark_hz);
		chk("tx_space_hz", sp, tx_space_hz);
		if (rc != 12'h000)
			chk("rx_carrier_hz", rc, rx_carrier_hz);
	endtask
	task automatic wait_ph(input int n);
		int t, s;
		s = ph_seen;
		t = 0;
		while (ph_seen < s + n) begin
			@(posedge aclk);
			t++;
			guard(t);
		end
	endtask
	// Watcher takes the oldest note whenever a result shows up
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", exp_b.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready) begin
			chk("rdata", exp_rd.pop_front(), s_axi_rdata);
			chk("rresp", exp_rr.pop_front(), s_axi_rresp);
		end
		if (rx_bit_clock && !rxc_q && exp_bit.size() > 0)
			chk("rxd_out", exp_bit.pop_front(), rxd_out);
		if (tx_bit_clock && !txc_q)
			txc_cnt++;
		if (mod_phase_stb) begin
			pb = pair_of(mod_phase);
			for (int j = 1; j >= 0; j--) begin
				run = pb[j] ? 0 : run + 1;
				max_zero = (run > max_zero) ? run : max_zero;
			end
			last_ph = mod_phase;
			ph_seen++;
		end
		rxc_q = rx_bit_clock;
		txc_q = tx_bit_clock;
	end
	// Limit on the whole run
	initial begin
		repeat (60000) @(posedge aclk);
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("rxd_out", 1'b1, rxd_out);
		chk("mod_fsk_bit", 1'b1, mod_fsk_bit);
		chk("tx_mark_hz", HZ_1200, tx_mark_hz);
		chk("rx_carrier_hz", HZ_2400, rx_carrier_hz);
		// Reset value, unmapped and read-only places, masked readback
		axi_read(REG_CTRL, CTRL_RST, RESP_OKAY);
		axi_read(8'h08, 32'h0, RESP_SLVERR);
		axi_write(8'h0c, 32'hffff_ffff, RESP_SLVERR);
		axi_write(REG_STAT, 32'hffff_ffff, RESP_OKAY);
		axi_read(REG_CTRL, CTRL_RST, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			axi_write(REG_CTRL, rnd, RESP_OKAY);
			axi_read(REG_CTRL, rnd & CTRL_MASK, RESP_OKAY);
		end
		// Only the lowest byte lane may land
		s_axi_wstrb <= 4'h1;
		axi_write(REG_CTRL, 32'hffff_ffff, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axi_read(REG_CTRL, rnd & CTRL_MASK & 32'hffff_ff00
			| CTRL_MASK & 32'hff, RESP_OKAY);
		tone_case(MODE_PSK, 3'h0, HZ_1200, HZ_1200, HZ_2400);
		tone_case(MODE_PSK, 3'h1, HZ_2400, HZ_2400, HZ_1200);
		tone_case(MODE_PSK, 3'h2, HZ_1200, HZ_1200, HZ_1200);
		tone_case(MODE_PSK, 3'h3, HZ_2400, HZ_2400, HZ_2400);
		tone_case(MODE_FSK300, 3'h0, HZ_1270, HZ_1070, HZ_2225);
		tone_case(MODE_FSK300, 3'h1, HZ_2225, HZ_2025, HZ_1270);
		tone_case(MODE_FSK1200, 3'h0, HZ_1200, HZ_2200, 12'h000);
		tone_case(MODE_FSK1200, 3'h4, HZ_387, HZ_487, 12'h000);
		// Frequency shift mode passes data straight through both ways
		carrier_detect <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rb = 1'($random(seed));
			dem_fsk_bit <= ~rb;
			term.set_level(rb);
			repeat (6) @(posedge aclk);
			chk("mod_fsk_bit", rb, mod_fsk_bit);
			chk("rxd_fsk", !rb, rxd_out);
		end
		carrier_detect <= 1'b0;
		// Async phase mode, scrambler off: idle marks, then a break
		axi_write(REG_CTRL, CTRL_RST | 32'h1 << B_SCRBYP, RESP_OKAY);
		wait_ph(3);
		chk("mod_phase", PH_270, last_ph);
		max_zero = 0;
		term.send_char(10, 16'h0000, 41);
		repeat (30 * BC) @(posedge aclk);
		chk("break_len", 1'b1, max_zero >= 2 * 10 + 3);
		// Synchronous receive: bits of each phase change, clocked out
		axi_write(REG_CTRL, CTRL_RST | 32'h1 << B_SYNC | 32'h1 << B_SCRBYP,
			RESP_OKAY);
		carrier_detect <= 1'b1;
		repeat (2 * BC) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			logic [1:0] q;
			rnd = $random(seed);
			q = pair_of(rnd[1:0]);
			dem_phase <= rnd[1:0];
			dem_phase_stb <= 1'b1;
			@(posedge aclk);
			dem_phase_stb <= 1'b0;
			// Note the bits once a free-running clock rise can't be seen
			repeat (2) @(posedge aclk);
			exp_bit.push_back(q[1]);
			exp_bit.push_back(q[0]);
			repeat (2 * BC - 3) @(posedge aclk);
		end
		repeat (2 * BC) @(posedge aclk);
		chk("rx_bits_left", 32'h0, exp_bit.size());
		carrier_detect <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("rxd_out", 1'b1, rxd_out);
		// Transmit clock from the external source, then the internal one
		axi_write(REG_CTRL, CTRL_RST | 32'h1 << B_SYNC
			| 32'(TSRC_EXT) << F_TSRC, RESP_OKAY);
		repeat (3 * BC) @(posedge aclk);
		txc_cnt = 0;
		term.ext_burst(12, $random(seed));
		repeat (10) @(posedge aclk);
		chk("tx_clock_ext", 32'd12, txc_cnt);
		axi_write(REG_CTRL, CTRL_RST | 32'h1 << B_SYNC, RESP_OKAY);
		repeat (3 * BC) @(posedge aclk);
		txc_cnt = 0;
		repeat (10 * BC) @(posedge aclk);
		chk("tx_clock_int", 1'b1, txc_cnt >= 9 && txc_cnt <= 11);
		report_and_stop();
	end
endmodule
`default_nettype wire
